// ==== logic/sbtc_pkg.sv ====
// Package of register offsets, field positions and constants for the wide counter
package sbtc_pkg;
  localparam int unsigned SBTC_ADDR_W = 3;
  localparam logic [2:0] SBTC_ADDR_COUNT_LOW = 3'h0;
  localparam logic [2:0] SBTC_ADDR_COUNT_HIGH = 3'h1;
  localparam logic [2:0] SBTC_ADDR_CONTROL = 3'h2;
  localparam logic [2:0] SBTC_ADDR_FLAGS_TWO = 3'h3;
  localparam logic [2:0] SBTC_ADDR_ENABLES_TWO = 3'h4;
  localparam logic [2:0] SBTC_ADDR_COMPANION_CTRL = 3'h5;
  localparam int unsigned SBTC_BIT_RUN = 0;
  localparam int unsigned SBTC_BIT_CLK_SRC = 1;
  localparam int unsigned SBTC_BIT_SYNC_BYPASS = 2;
  localparam int unsigned SBTC_BIT_TIMEBASE = 3;
  localparam int unsigned SBTC_BIT_PRESCALE_LO = 4;
  localparam int unsigned SBTC_BIT_WIDE_MODE = 7;
  localparam int unsigned SBTC_BIT_OVF = 1;
  localparam int unsigned SBTC_BIT_AUX_OSC = 3;
  localparam logic [7:0] SBTC_CONTROL_MASK = 8'hBF;
  localparam logic [7:0] SBTC_CONTROL_RESET = 8'h00;
  localparam logic [15:0] SBTC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] SBTC_COUNT_MAX = 16'hFFFF;
  localparam logic [3:0] SBTC_CCP_SPECIAL_EVENT = 4'hB;
  localparam logic [1:0] SBTC_INST_PHASE_LAST = 2'h3;
  localparam int unsigned SBTC_PIN_COUNT = 2;
  localparam int unsigned SBTC_PIN_EXT = 0;
  localparam int unsigned SBTC_PIN_AUX = 1;
endpackage : sbtc_pkg

// ==== logic/sbtc_pin_sync.sv ====
// Two-flop synchronisers with rise and fall detection for the count pins
`timescale 1ns/10ps
`default_nettype none
module sbtc_pin_sync
  import sbtc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [SBTC_PIN_COUNT-1:0] i_pins,
  output logic [SBTC_PIN_COUNT-1:0] o_level,
  output logic [SBTC_PIN_COUNT-1:0] o_rise,
  output logic [SBTC_PIN_COUNT-1:0] o_fall
);
  typedef struct packed {
    logic [SBTC_PIN_COUNT-1:0] meta;
    logic [SBTC_PIN_COUNT-1:0] sync;
    logic [SBTC_PIN_COUNT-1:0] last;
  } sbtc_sync_s;

  sbtc_sync_s state_reg;
  sbtc_sync_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.meta = i_pins;
    state_next.sync = state_reg.meta;
    state_next.last = state_reg.sync;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SBTC_PIN_COUNT; g++) begin : g_pin
      assign o_level[g] = state_reg.sync[g];
      assign o_rise[g] = state_reg.sync[g] & ~state_reg.last[g];
      assign o_fall[g] = ~state_reg.sync[g] & state_reg.last[g];
    end
  endgenerate
endmodule : sbtc_pin_sync
`default_nettype wire

// ==== logic/sbtc_prescaler.sv ====
// Count-clock prescaler dividing by one, two, four or eight
`timescale 1ns/10ps
`default_nettype none
module sbtc_prescaler
  import sbtc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic [1:0] i_select,
  output logic o_tick
);
  typedef struct packed {
    logic [2:0] div;
  } sbtc_pre_s;

  sbtc_pre_s state_reg;
  sbtc_pre_s state_next;
  logic [2:0] limit;

  always_comb begin
    case (i_select)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      default: limit = 3'h7;
    endcase
  end

  assign o_tick = i_tick && !i_clear && (state_reg.div == limit); // see [R5]

  always_comb begin
    state_next = state_reg;
    if (i_clear) begin
      state_next.div = 3'h0; // see [R21]
    end else if (i_tick) begin
      state_next.div = (state_reg.div == limit) ? 3'h0 : state_reg.div + 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : sbtc_prescaler
`default_nettype wire

// ==== logic/sbtc_timer.sv ====
// Sixteen-bit timer/counter with prescaler, overflow flag and trigger reset
//
// Notes on behaviour
// [R1] Count is 16 bits, held as readable, writable high and low bytes.
// [R2] Source select 0 counts instruction clock, one per four system clocks.
// [R3] Source select 1 counts rising edges of count pin or aux oscillator.
// [R4] External mode counts only after a falling edge seen since selection.
// [R5] Prescale field bits 5:4 divide by 1, 2, 4 or 8.
// [R6] External mode: bypass 0 syncs to instruction clock, 1 counts directly.
// [R7] Internal source ignores the sync bypass bit.
// [R8] Run bit 0 set lets the counter count; clear stops it.
// [R9] Control bit 7 picks one 16-bit access or two byte accesses.
// [R10] Bit 3 routes this counter to capture/compare as time base.
// [R11] Count runs 0000h to FFFFh then wraps to 0000h.
// [R12] Wrap sets overflow flag, bit 1 of flag register, until cleared.
// [R13] Overflow interrupt only while enable bit 1 is set.
// [R14] Internal reset input clears count, driven by special event trigger.
// [R15] Aux oscillator is a source, enabled by companion control bit 3.
// [R16] Aux oscillator on forces its two pins to inputs reading 0.
// [R17] Compare mode 1011 with match resets the count to zero.
// [R18] Trigger reset never sets the overflow flag.
// [R19] Software count write wins over simultaneous trigger reset.
// [R20] Wide mode: low read latches high byte; low write loads buffered high.
// [R21] Count or control writes clear the prescaler divide counter.
`timescale 1ns/10ps
`default_nettype none
module sbtc_timer
  import sbtc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [SBTC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_count_input,
  input wire logic i_aux_osc_clk,
  input wire logic [3:0] i_capcomp_mode_field,
  input wire logic i_capcomp_match,
  output logic [15:0] o_count,
  output logic o_capture_timebase_select,
  output logic o_overflow_irq,
  output logic o_aux_pins_force_input,
  output logic o_aux_pins_read_zero
);
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] high_buf;
    logic [7:0] control;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic aux_osc_enable;
    logic armed;
    logic sync_pending;
    logic [1:0] phase;
    logic [7:0] rdata;
  } sbtc_state_s;

  sbtc_state_s state_reg;
  sbtc_state_s state_next;
  logic rst_meta_n;
  logic rst_n;
  logic [SBTC_PIN_COUNT-1:0] pin_rise;
  logic [SBTC_PIN_COUNT-1:0] pin_fall;
  logic inst_tick;
  logic ext_rise;
  logic ext_fall;
  logic ext_tick;
  logic raw_tick;
  logic pre_tick;
  logic pre_clear;
  logic trig_reset;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic wide;
  logic clk_src;

  // Reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  sbtc_pin_sync u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_pins({i_aux_osc_clk, i_ext_count_input}),
    .o_level(),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  assign wide = state_reg.control[SBTC_BIT_WIDE_MODE];
  assign clk_src = state_reg.control[SBTC_BIT_CLK_SRC];
  assign wr_low = i_wr && (i_addr == SBTC_ADDR_COUNT_LOW);
  assign wr_high = i_wr && (i_addr == SBTC_ADDR_COUNT_HIGH);
  assign wr_ctrl = i_wr && (i_addr == SBTC_ADDR_CONTROL);
  assign inst_tick = (state_reg.phase == SBTC_INST_PHASE_LAST); // see [R2]

  // Selected external source: aux oscillator when enabled, else count pin
  assign ext_rise = state_reg.aux_osc_enable ? pin_rise[SBTC_PIN_AUX] : // see [R3] [R15]
    pin_rise[SBTC_PIN_EXT];
  assign ext_fall = state_reg.aux_osc_enable ? pin_fall[SBTC_PIN_AUX] : pin_fall[SBTC_PIN_EXT];

  always_comb begin
    if (state_reg.control[SBTC_BIT_SYNC_BYPASS]) begin
      ext_tick = ext_rise && state_reg.armed; // see [R6] [R4]
    end else begin
      ext_tick = inst_tick && // see [R6]
        (state_reg.sync_pending || (ext_rise && state_reg.armed));
    end
  end

  // Sync bypass plays no part while the internal source is selected
  assign raw_tick = state_reg.control[SBTC_BIT_RUN] && // see [R7] [R8]
    (clk_src ? ext_tick : inst_tick);

  // A byte write to the high half in wide mode only fills the buffer
  assign pre_clear = wr_low || wr_ctrl || (wr_high && !wide); // see [R21]

  sbtc_prescaler u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_tick(raw_tick),
    .i_clear(pre_clear),
    .i_select(state_reg.control[SBTC_BIT_PRESCALE_LO +: 2]),
    .o_tick(pre_tick)
  );

  assign trig_reset = i_capcomp_match && // see [R14] [R17]
    (i_capcomp_mode_field == SBTC_CCP_SPECIAL_EVENT);

  always_comb begin
    state_next = state_reg;
    state_next.phase = state_reg.phase + 2'h1;
    // Pending synchronised edge waits for the next instruction boundary
    if (!clk_src || state_reg.control[SBTC_BIT_SYNC_BYPASS] || inst_tick) begin
      state_next.sync_pending = 1'b0;
    end else if (ext_rise && state_reg.armed) begin
      state_next.sync_pending = 1'b1;
    end
    if (ext_fall) begin
      state_next.armed = 1'b1; // see [R4]
    end
    // Counting and overflow
    if (pre_tick) begin
      state_next.count = state_reg.count + 16'h0001; // see [R11]
      // A trigger reset in the same cycle takes the count, so no wrap happens
      if (state_reg.count == SBTC_COUNT_MAX && !trig_reset) begin
        state_next.overflow_flag = 1'b1; // see [R12] [R18]
      end
    end
    if (trig_reset) begin
      state_next.count = SBTC_COUNT_RESET; // see [R14] [R18]
    end
    // Count writes win over counting and trigger reset; a wrap beats a flag clear write
    if (wr_low) begin
      state_next.count[7:0] = i_wdata; // see [R19]
      if (wide) begin
        state_next.count[15:8] = state_reg.high_buf; // see [R20]
      end else if (trig_reset) begin
        state_next.count[15:8] = state_reg.count[15:8];
      end
    end
    if (wr_high) begin
      if (wide) begin
        state_next.high_buf = i_wdata; // see [R20] [R9]
      end else begin
        state_next.count[15:8] = i_wdata; // see [R1] [R19]
        if (trig_reset) begin
          state_next.count[7:0] = state_reg.count[7:0];
        end
      end
    end
    if (wr_ctrl) begin
      state_next.control = i_wdata & SBTC_CONTROL_MASK;
      // A falling edge seen in the selecting cycle still arms the counter
      if (i_wdata[SBTC_BIT_CLK_SRC] && !clk_src && !ext_fall) begin
        state_next.armed = 1'b0; // see [R4]
      end
    end
    if (i_wr && (i_addr == SBTC_ADDR_FLAGS_TWO) && !i_wdata[SBTC_BIT_OVF]) begin
      // A wrap in the same cycle keeps the flag set
      if (!(pre_tick && state_reg.count == SBTC_COUNT_MAX && !trig_reset)) begin
        state_next.overflow_flag = 1'b0; // see [R12]
      end
    end
    if (i_wr && (i_addr == SBTC_ADDR_ENABLES_TWO)) begin
      state_next.overflow_irq_enable = i_wdata[SBTC_BIT_OVF];
    end
    if (i_wr && (i_addr == SBTC_ADDR_COMPANION_CTRL)) begin
      state_next.aux_osc_enable = i_wdata[SBTC_BIT_AUX_OSC]; // see [R15]
    end
    // Read path, data valid the cycle after the strobe
    state_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        SBTC_ADDR_COUNT_LOW: begin
          state_next.rdata = state_reg.count[7:0];
          if (wide) begin
            state_next.high_buf = state_reg.count[15:8]; // see [R20]
          end
        end
        SBTC_ADDR_COUNT_HIGH: begin
          state_next.rdata = wide ? state_reg.high_buf : state_reg.count[15:8]; // see [R9]
        end
        SBTC_ADDR_CONTROL: begin
          state_next.rdata = state_reg.control;
        end
        SBTC_ADDR_FLAGS_TWO: begin
          state_next.rdata[SBTC_BIT_OVF] = state_reg.overflow_flag;
        end
        SBTC_ADDR_ENABLES_TWO: begin
          state_next.rdata[SBTC_BIT_OVF] = state_reg.overflow_irq_enable;
        end
        SBTC_ADDR_COMPANION_CTRL: begin
          state_next.rdata[SBTC_BIT_AUX_OSC] = state_reg.aux_osc_enable;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_count = state_reg.count;
  assign o_capture_timebase_select = state_reg.control[SBTC_BIT_TIMEBASE]; // see [R10]
  assign o_overflow_irq = state_reg.overflow_flag && state_reg.overflow_irq_enable; // see [R13]
  assign o_aux_pins_force_input = state_reg.aux_osc_enable; // see [R16]
  assign o_aux_pins_read_zero = state_reg.aux_osc_enable; // see [R16]
endmodule : sbtc_timer
`default_nettype wire

// ==== verif/sbtc_far_side.sv ====
// Model of the count pin, the auxiliary oscillator and the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module sbtc_far_side (
  input wire logic i_clk_sys,
  output logic o_pin,
  output logic o_aux,
  output logic [3:0] o_mode,
  output logic o_match
);
  initial begin
    o_pin = 1'b0;
    o_aux = 1'b0;
    o_mode = 4'h0;
    o_match = 1'b0;
  end
  // Pulses start low and stay eight clocks per level, well above one clock
  task automatic pulses(input logic aux, input int n);
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge i_clk_sys);
      if (aux) o_aux <= !o_aux;
      else o_pin <= !o_pin;
      repeat (7) @(posedge i_clk_sys);
    end
  endtask : pulses
  // Compare match of one clock; the mode field holds afterwards
  task automatic fire(input logic [3:0] m);
    @(posedge i_clk_sys);
    o_mode <= m;
    o_match <= 1'b1;
    @(posedge i_clk_sys);
    o_match <= 1'b0;
    #1;
  endtask : fire
endmodule : sbtc_far_side
`default_nettype wire

// ==== verif/sbtc_timer_asserts.sv ====
// Checker of counting, trigger and control outputs of the wide counter
`timescale 1ns/10ps
`default_nettype none
module sbtc_timer_asserts
  import sbtc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [SBTC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [3:0] i_capcomp_mode_field,
  input wire logic i_capcomp_match,
  input wire logic [15:0] o_count,
  input wire logic o_capture_timebase_select,
  input wire logic o_overflow_irq,
  input wire logic o_aux_pins_force_input,
  input wire logic o_aux_pins_read_zero
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [7:0] ctl_reg;
  logic ie_reg;
  logic [6:0] quiet_reg;
  logic trig;
  assign trig = i_capcomp_match && i_capcomp_mode_field == SBTC_CCP_SPECIAL_EVENT;
  // Cycles since the last write or match, saturating
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_reg <= 8'h00;
      ie_reg <= 1'b0;
      quiet_reg <= 7'h00;
    end else begin
      if (i_wr && i_addr == SBTC_ADDR_CONTROL) ctl_reg <= i_wdata;
      if (i_wr && i_addr == SBTC_ADDR_ENABLES_TWO) ie_reg <= i_wdata[SBTC_BIT_OVF];
      quiet_reg <= (i_wr || i_capcomp_match) ? 7'h00 : quiet_reg + {6'h00, quiet_reg != 7'h7F};
    end
  end
  property p_trig_zero;
    trig && !(i_wr && i_addr <= SBTC_ADDR_COUNT_HIGH) |=> o_count == 16'h0000;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger missed reset");
  property p_trig_noflag;
    trig && !i_wr && !o_overflow_irq |=> !o_overflow_irq;
  endproperty
  a_trig_noflag: assert property (p_trig_noflag) else $error("trigger set overflow");
  property p_timebase;
    i_wr && i_addr == SBTC_ADDR_CONTROL |=> o_capture_timebase_select == $past(i_wdata[3]);
  endproperty
  a_timebase: assert property (p_timebase) else $error("timebase select wrong");
  property p_aux;
    i_wr && i_addr == SBTC_ADDR_COMPANION_CTRL |=>
      o_aux_pins_force_input == $past(i_wdata[3]) && o_aux_pins_read_zero == $past(i_wdata[3]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux pin outputs wrong");
  property p_irq_mask;
    !ie_reg |-> !o_overflow_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
  property p_step;
    !$past(i_wr) && !$past(i_capcomp_match) && o_count != $past(o_count)
      |-> o_count == $past(o_count) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count moved by other than one");
  property p_wrap;
    $past(o_count) == 16'hFFFF && o_count == 16'h0000 && !$past(i_wr) && !$past(i_capcomp_match)
      && ie_reg |-> ##[0:1] o_overflow_irq;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without overflow");
  property p_run_stop;
    quiet_reg >= 7'h08 && !ctl_reg[SBTC_BIT_RUN] |-> $stable(o_count);
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("count moved while stopped");
  property p_tick1;
    quiet_reg >= 7'h0C && ctl_reg[1:0] == 2'b01 && ctl_reg[5:4] == 2'b00
      |-> o_count == $past(o_count, 4) + 16'h0001;
  endproperty
  a_tick1: assert property (p_tick1) else $error("internal rate wrong");
  property p_tick8;
    quiet_reg >= 7'h28 && ctl_reg[1:0] == 2'b01 && ctl_reg[5:4] == 2'b11
      |-> o_count == $past(o_count, 32) + 16'h0001;
  endproperty
  a_tick8: assert property (p_tick8) else $error("divide by eight rate wrong");
endmodule : sbtc_timer_asserts
bind sbtc_timer sbtc_timer_asserts u_chk (.i_clk_sys, .i_resetn, .i_addr, .i_wdata, .i_wr,
  .i_capcomp_mode_field, .i_capcomp_match, .o_count, .o_capture_timebase_select,
  .o_overflow_irq, .o_aux_pins_force_input, .o_aux_pins_read_zero);
`default_nettype wire

// ==== verif/sbtc_timer_test.sv ====
// Register-level testbench of the wide counter
`timescale 1ns/10ps
`default_nettype none
module sbtc_timer_test
  import sbtc_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic [SBTC_ADDR_W-1:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [15:0] o_count;
  logic [3:0] mode;
  logic ext_pin, aux_clk, match, tb_sel, irq, force_in, read_zero;
  int fail_count = 0;
  int check_count = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  sbtc_timer u_dut (.i_clk_sys, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ext_count_input(ext_pin), .i_aux_osc_clk(aux_clk), .i_capcomp_mode_field(mode),
    .i_capcomp_match(match), .o_count, .o_capture_timebase_select(tb_sel),
    .o_overflow_irq(irq), .o_aux_pins_force_input(force_in), .o_aux_pins_read_zero(read_zero));
  sbtc_far_side u_far (.i_clk_sys, .o_pin(ext_pin), .o_aux(aux_clk), .o_mode(mode),
    .o_match(match));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(n, {8'h00, o_rdata}, {8'h00, e});
  endtask : rd
  task automatic wcount(input logic [15:0] v);
    wr(SBTC_ADDR_COUNT_LOW, v[7:0]);
    wr(SBTC_ADDR_COUNT_HIGH, v[15:8]);
  endtask : wcount
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd(2, 8'h00, "control");
    rd(0, 8'h00, "low");
    wr(2, 8'hFF);
    rd(2, 8'hBF, "control");
    chk("timebase", {15'h0000, tb_sel}, 16'h0001);
    wr(2, 8'h00);
    wcount(16'h1234);
    chk("count", o_count, 16'h1234);
    rd(1, 8'h12, "high");
    wr(2, 8'h80);
    wr(1, 8'hAB);
    chk("count", o_count, 16'h1234);
    wr(0, 8'hCD);
    chk("count", o_count, 16'hABCD);
    wr(1, 8'h55);
    rd(0, 8'hCD, "low");
    rd(1, 8'hAB, "buffer");
    wr(2, 8'h00);
    wcount(16'hFFFE);
    wr(4, 8'h02);
    wr(2, 8'h05);
    repeat (16) @(posedge i_clk_sys);
    wr(2, 8'h00);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(3, 8'h02, "flags");
    wr(4, 8'h00);
    chk("irq", {15'h0000, irq}, 16'h0000);
    wr(4, 8'h02);
    wr(3, 8'h00);
    chk("irq", {15'h0000, irq}, 16'h0000);
    for (int m = 0; m < 16; m++) begin
      wcount(16'h0005);
      u_far.fire(4'(m));
      chk("trigger", o_count, (m == 11) ? 16'h0000 : 16'h0005);
    end
    rd(3, 8'h00, "flags");
    wcount(16'h1200);
    fork
      wr(0, 8'h77);
      u_far.fire(4'hB);
    join
    chk("write wins", o_count, 16'h1277);
    for (int ps = 0; ps < 4; ps++) begin
      wcount(16'h0000);
      wr(2, {2'b00, 2'(ps), 4'h5});
      repeat (32 << ps) @(posedge i_clk_sys);
      wr(2, 8'h00);
      chk("prescale", {15'h0000, o_count > 16'h0006 && o_count < 16'h000A}, 16'h0001);
    end
    for (int s = 0; s < 2; s++) begin
      wcount(16'h0000);
      wr(2, (s == 0) ? 8'h03 : 8'h07);
      u_far.pulses(1'b0, 4);
      wr(2, 8'h00);
      chk("external", o_count, 16'h0003);
    end
    wr(5, 8'h08);
    chk("forced", {14'h0000, force_in, read_zero}, 16'h0003);
    wcount(16'h0000);
    wr(2, 8'h03);
    u_far.pulses(1'b1, 3);
    wr(2, 8'h00);
    chk("aux", o_count, 16'h0002);
    wr(5, 8'h00);
    chk("forced", {14'h0000, force_in, read_zero}, 16'h0000);
    print_verdict();
  end
endmodule : sbtc_timer_test
`default_nettype wire
